// *** verif/flut11_tb.sv ***
// Self-checking bench for the LUT entry eleven register bank and compare logic.
`include "flut11_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk; // System clock, 100 MHz.
  logic rst; // Synchronous reset, active high.
  logic [11:0] paddr; // APB byte address.
  logic psel; // APB select.
  logic penable; // APB access phase.
  logic pwrite; // APB direction.
  logic [31:0] pwdata; // APB write data.
  logic [31:0] prdata; // APB read data.
  logic pready; // APB answer strobe.
  logic pslverr; // APB error flag.
  logic [10:0] temp_reading; // Remote temperature in eighths of a degree.
  logic entry_exceeded; // Compare result.
  logic [7:0] entry_duty; // Duty view when exceeded.
  int bad_count; // Mismatches seen.
  int num_checks; // Comparisons made.
  logic [31:0] rdat; // Last read data.
  logic rerr; // Last error flag.

  flut11_top dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .temp_reading(temp_reading), .entry_exceeded(entry_exceeded), .entry_duty(entry_duty));

  // Free-running clock with a 10 ns period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Prints the verdict and ends the run; also reached when a wait runs out.
  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // Compares with case equality so an unknown never counts as a match.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      // A slave that never answers would hang the run, so it is cut short here.
      bad_count++;
      $display("mismatch at %0t: no answer from slave", $time);
      tally_and_finish();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // Register write that expects no error.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    chk({31'h0, rerr}, 32'h0);
  endtask : wr

  // Register read compared against an expected word, with no error.
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rdat, exp);
    chk({31'h0, rerr}, 32'h0);
  endtask : rd

  // Applies a temperature and checks the compare outputs once they have settled.
  task automatic tchk(input logic [10:0] t, input logic exc, input logic [7:0] d);
    @(posedge clk);
    temp_reading <= t;
    repeat (3) @(posedge clk);
    chk({23'h0, entry_exceeded, entry_duty}, {23'h0, exc, d});
  endtask : tchk

  // Main sequence: reset, access rules, then the compare with mode values 0, 1, 3 and 7.
  initial begin
    bad_count = 0;
    num_checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    temp_reading = 11'h000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`FLUT11_IDX_LIMIT, 32'h0000007F);
    rd(`FLUT11_IDX_DUTY, 32'h0000003F);
    // Locked writes must leave the limit register untouched.
    wr(`FLUT11_IDX_LIMIT, 8'hB2);
    rd(`FLUT11_IDX_LIMIT, 32'h0000007F);
    // An unmapped place answers with an error and zero data.
    apb(1'b0, 8'h00, 8'h00);
    chk(rdat, 32'h00000000);
    chk({31'h0, rerr}, 32'h00000001);
    wr(`FLUT11_IDX_UNLOCK, 8'h20);
    wr(`FLUT11_IDX_LIMIT, 8'hB2);
    rd(`FLUT11_IDX_LIMIT, 32'h00000032);
    wr(`FLUT11_IDX_DUTY, 8'hC5);
    rd(`FLUT11_IDX_DUTY, 32'h00000005);
    // Low mode: limit is 50 whole degrees, only eight bits of the reading count.
    tchk(11'd407, 1'b0, 8'h00);
    tchk(11'd408, 1'b1, 8'h05);
    // High temperature mode: 0xB2 is 89.0 degrees, bit 7 taken as magnitude.
    wr(`FLUT11_IDX_MODE, 8'h01);
    rd(`FLUT11_IDX_LIMIT, 32'h000000B2);
    tchk(11'd714, 1'b0, 8'h00);
    tchk(11'd716, 1'b1, 8'h05);
    // Extended duty bits stay dormant unless 22.5 kHz is also chosen.
    wr(`FLUT11_IDX_MODE, 8'h03);
    rd(`FLUT11_IDX_DUTY, 32'h00000005);
    tchk(11'd716, 1'b1, 8'h05);
    wr(`FLUT11_IDX_MODE, 8'h07);
    rd(`FLUT11_IDX_DUTY, 32'h000000C5);
    tchk(11'd716, 1'b1, 8'hC5);
    // Offset of 100 degrees lifts the low mode limit to 150 degrees.
    wr(`FLUT11_IDX_MODE, 8'h00);
    wr(`FLUT11_IDX_TOFS, 8'h64);
    tchk(11'd1207, 1'b0, 8'h00);
    tchk(11'd1208, 1'b1, 8'h05);
    rd(`FLUT11_IDX_STATUS, 32'h00000105);
    // Relocking blocks further limit and duty programming.
    wr(`FLUT11_IDX_UNLOCK, 8'h00);
    wr(`FLUT11_IDX_DUTY, 8'h00);
    rd(`FLUT11_IDX_DUTY, 32'h00000005);
    tally_and_finish();
  end
endmodule : testbench

// *** verilog/flut11_defs.svh ***
// Offsets, field positions, reset values and timing for LUT entry eleven.
`ifndef FLUT11_DEFS_SVH
`define FLUT11_DEFS_SVH
// Register indexes as printed; the byte address is four times the index.
`define FLUT11_IDX_UNLOCK 8'h4A
`define FLUT11_IDX_TOFS 8'h4E
`define FLUT11_IDX_LIMIT 8'h64
`define FLUT11_IDX_DUTY 8'h65
`define FLUT11_IDX_MODE 8'h70
`define FLUT11_IDX_STATUS 8'h71
// Field positions.
`define FLUT11_UNLOCK_BIT 5
`define FLUT11_LIMIT_HALF_BIT 7
`define FLUT11_MODE_TEMP_HI_BIT 0
`define FLUT11_MODE_DUTY_HI_BIT 1
`define FLUT11_MODE_PWM_22K5_BIT 2
// Reset values.
`define FLUT11_LIMIT_RST 8'h7F
`define FLUT11_DUTY_RST 8'h3F
`define FLUT11_TOFS_RST 8'h00
`define FLUT11_UNLOCK_RST 8'h00
`define FLUT11_MODE_RST 3'h0
// Wait states the slave inserts in every access phase.
`define FLUT11_APB_WAITS 1
`endif

// *** verilog/flut11_pkg.sv ***
// Types shared by the LUT entry eleven register bank.
package flut11_pkg;
  // Mode bits that steer interpretation of the entry.
  typedef struct packed {
    logic pwm_22k5;
    logic duty_hires;
    logic temp_hires;
  } flut11_mode_s;
  // Bus handshake phase of the slave.
  typedef enum logic {
    APB_IDLE,
    APB_ACK
  } flut11_apb_e;
endpackage : flut11_pkg

// *** verilog/flut11_top.sv ***
// APB register bank and compare logic for fan LUT entry eleven.
// Summary of operation
// - Low temp mode: limit bit7 ignored, reads zero.
// - High temp mode: eight bits, half degrees.
// - Low temp mode: seven bits, whole degrees.
// - Temperature above limit selects this duty.
// - Compare nine bits high, eight low.
// - Limit is unsigned, sign assumed zero.
// - Table offset register adds to limit.
// - Low duty mode: upper bits read zero.
// - High duty mode: eight bit duty.
// - Extended duty bits need 22.5 kHz.
// - Low PWM mode: six bit duty.
//
// Added by the designer: the APB interface to the registers.
`include "flut11_defs.svh"
module flut11_top
  import flut11_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] temp_reading,
  output logic entry_exceeded,
  output logic [7:0] entry_duty
);

  // Byte address of a printed register index.
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction : reg_addr

  // Register state.
  logic [7:0] limit_ff, nxt_limit; // Temperature limit of this entry.
  logic [7:0] duty_ff, nxt_duty; // Paired duty value.
  logic [7:0] tofs_ff, nxt_tofs; // Shared table offset in degrees.
  logic [7:0] unlock_ff, nxt_unlock; // Unlock register.
  flut11_mode_s mode_ff, nxt_mode; // Resolution and frequency modes.

  // Bus state.
  flut11_apb_e apb_ff, nxt_apb;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  // Compare outputs.
  logic exceed_ff, nxt_exceed;
  logic [7:0] eduty_ff, nxt_eduty;

  // Decode helpers.
  logic hit_limit, hit_duty, hit_tofs, hit_unlock, hit_mode, hit_status;
  logic mapped, wr_done, unlocked;
  logic [7:0] limit_view, duty_view;
  logic ext_active;
  logic [9:0] lim_hi;
  logic [8:0] lim_lo;

  // Address decode, as an if chain so a stray address falls to the end.
  always_comb begin
    hit_limit = 1'b0;
    hit_duty = 1'b0;
    hit_tofs = 1'b0;
    hit_unlock = 1'b0;
    hit_mode = 1'b0;
    hit_status = 1'b0;
    if (paddr == reg_addr(`FLUT11_IDX_LIMIT)) begin
      hit_limit = 1'b1;
    end else if (paddr == reg_addr(`FLUT11_IDX_DUTY)) begin
      hit_duty = 1'b1;
    end else if (paddr == reg_addr(`FLUT11_IDX_TOFS)) begin
      hit_tofs = 1'b1;
    end else if (paddr == reg_addr(`FLUT11_IDX_UNLOCK)) begin
      hit_unlock = 1'b1;
    end else if (paddr == reg_addr(`FLUT11_IDX_MODE)) begin
      hit_mode = 1'b1;
    end else if (paddr == reg_addr(`FLUT11_IDX_STATUS)) begin
      hit_status = 1'b1;
    end
  end

  // Shared views of the entry as the current modes see it.
  always_comb begin
    mapped = hit_limit | hit_duty | hit_tofs | hit_unlock | hit_mode | hit_status;
    // A write lands only on the edge where the master sees pready.
    wr_done = psel & penable & pready_ff & pwrite;
    unlocked = unlock_ff[`FLUT11_UNLOCK_BIT];
    // The half-degree bit only counts in high resolution.
    limit_view = limit_ff;
    if (!mode_ff.temp_hires) begin
      limit_view[`FLUT11_LIMIT_HALF_BIT] = 1'b0;
    end
    // Extended duty bits need both high resolution and the fast PWM.
    ext_active = mode_ff.duty_hires & mode_ff.pwm_22k5;
    duty_view = ext_active ? duty_ff : {2'b00, duty_ff[5:0]};
  end

  // Register writes; while locked, limit and duty simply keep their contents.
  always_comb begin
    nxt_limit = limit_ff;
    nxt_duty = duty_ff;
    nxt_tofs = tofs_ff;
    nxt_unlock = unlock_ff;
    nxt_mode = mode_ff;
    if (wr_done) begin
      if (hit_limit && unlocked) begin
        nxt_limit = pwdata[7:0];
      end else if (hit_duty && unlocked) begin
        nxt_duty = pwdata[7:0];
      end else if (hit_tofs) begin
        nxt_tofs = pwdata[7:0];
      end else if (hit_unlock) begin
        nxt_unlock = pwdata[7:0];
      end else if (hit_mode) begin
        nxt_mode = flut11_mode_s'(pwdata[2:0]);
      end
    end
  end

  // Register storage.
  always_ff @(posedge clk) begin
    if (rst) begin
      limit_ff <= `FLUT11_LIMIT_RST;
      duty_ff <= `FLUT11_DUTY_RST;
      tofs_ff <= `FLUT11_TOFS_RST;
      unlock_ff <= `FLUT11_UNLOCK_RST;
      mode_ff <= flut11_mode_s'(`FLUT11_MODE_RST);
    end else begin
      limit_ff <= nxt_limit;
      duty_ff <= nxt_duty;
      tofs_ff <= nxt_tofs;
      unlock_ff <= nxt_unlock;
      mode_ff <= nxt_mode;
    end
  end

  // Slave handshake: one wait state, then pready for one cycle.
  // Read data is captured as pready rises so it stands with it.
  always_comb begin
    nxt_apb = apb_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    case (apb_ff)
      APB_IDLE: begin
        if (psel && penable) begin
          nxt_apb = APB_ACK;
          nxt_pready = 1'b1;
          nxt_pslverr = ~mapped;
          nxt_prdata = 32'h0000_0000;
          if (!pwrite) begin
            if (hit_limit) begin
              nxt_prdata[7:0] = limit_view;
            end else if (hit_duty) begin
              nxt_prdata[7:0] = duty_view;
            end else if (hit_tofs) begin
              nxt_prdata[7:0] = tofs_ff;
            end else if (hit_unlock) begin
              nxt_prdata[7:0] = unlock_ff;
            end else if (hit_mode) begin
              nxt_prdata[2:0] = mode_ff;
            end else if (hit_status) begin
              nxt_prdata[8:0] = {exceed_ff, eduty_ff};
            end
          end
        end
      end
      APB_ACK: begin
        nxt_apb = APB_IDLE;
      end
      default: begin
        nxt_apb = APB_IDLE;
      end
    endcase
  end

  // Slave handshake registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      apb_ff <= APB_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      apb_ff <= nxt_apb;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // Limit compare. The limit is unsigned and the offset widens the range,
  // so the sums carry one extra bit instead of wrapping at 255 degrees.
  always_comb begin
    // Half-degree units: integer and half bit, offset doubled.
    lim_hi = {2'b00, limit_ff} + {1'b0, tofs_ff, 1'b0};
    // Whole-degree units: seven bits plus the offset.
    lim_lo = {2'b00, limit_ff[6:0]} + {1'b0, tofs_ff};
    if (mode_ff.temp_hires) begin
      nxt_exceed = {1'b0, temp_reading[10:2]} > lim_hi;
    end else begin
      nxt_exceed = {1'b0, temp_reading[10:3]} > lim_lo;
    end
    // Six-bit duty alone unless the extended bits are live.
    nxt_eduty = nxt_exceed ? duty_view : 8'h00;
  end

  // Compare result registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      exceed_ff <= 1'b0;
      eduty_ff <= 8'h00;
    end else begin
      exceed_ff <= nxt_exceed;
      eduty_ff <= nxt_eduty;
    end
  end

  // Outputs come straight from flip-flops.
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign entry_exceeded = exceed_ff;
  assign entry_duty = eduty_ff;

  // Checks on the bank and the compare path.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_limit_msb_read: assert property (
    pready && !pwrite && hit_limit && !mode_ff.temp_hires |-> prdata[7] == 1'b0)
    else $error("limit bit 7 not zero in low resolution");

  a_hires_compare: assert property (
    mode_ff.temp_hires && ({1'b0, temp_reading[10:2]} >
      ({2'b00, limit_ff} + {1'b0, tofs_ff, 1'b0})) |=> entry_exceeded)
    else $error("high resolution compare missed");

  a_lores_compare: assert property (
    !mode_ff.temp_hires && ({1'b0, temp_reading[10:3]} <=
      ({2'b00, limit_ff[6:0]} + {1'b0, tofs_ff})) |=> !entry_exceeded)
    else $error("low resolution compare false hit");

  // The duty shown is the view in force at the edge that raised the compare, so a mode write
  // in the same cycle must not be taken as a fault.
  a_exceed_duty: assert property (
    nxt_exceed |=> entry_exceeded && entry_duty == $past(duty_view))
    else $error("entry duty not driven when exceeded");

  a_idle_zero: assert property (
    !nxt_exceed |=> !entry_exceeded && entry_duty == 8'h00)
    else $error("entry duty not zero below limit");

  a_hires_quiet: assert property (
    mode_ff.temp_hires && ({1'b0, temp_reading[10:2]} <=
      ({2'b00, limit_ff} + {1'b0, tofs_ff, 1'b0})) |=> !entry_exceeded)
    else $error("high resolution compare false hit");

  a_lores_hit: assert property (
    !mode_ff.temp_hires && ({1'b0, temp_reading[10:3]} >
      ({2'b00, limit_ff[6:0]} + {1'b0, tofs_ff})) |=> entry_exceeded)
    else $error("low resolution compare missed");

  a_hires_read: assert property (
    pready && !pwrite && hit_limit && mode_ff.temp_hires |-> prdata[7:0] == limit_ff)
    else $error("limit bit 7 lost in high resolution read");

  // Full eight-bit duty must pass only while the extended bits are live.
  a_duty_ext_live: assert property (
    ext_active && nxt_exceed |=> entry_duty == $past(duty_ff))
    else $error("extended duty bits not applied");

  a_low_duty_six: assert property (
    !ext_active && nxt_exceed |=> entry_duty == ($past(duty_ff) & 8'h3F))
    else $error("six bit duty not applied in low mode");

  // A stray address answers with an error and never leaks stale data.
  a_unmapped_err: assert property (
    pready && !mapped |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  a_locked_write: assert property (
    wr_done && !unlocked |=> $stable(limit_ff) && $stable(duty_ff))
    else $error("entry written while locked");

  a_unlocked_write: assert property (
    wr_done && unlocked && hit_limit |=> limit_ff == $past(pwdata[7:0]))
    else $error("unlocked limit write lost");

  a_duty_ext_zero: assert property (
    !ext_active ##1 entry_exceeded && !ext_active |-> entry_duty[7:6] == 2'b00)
    else $error("extended duty bits active outside 22.5 kHz high mode");

  a_duty_read_zero: assert property (
    pready && !pwrite && hit_duty && !mode_ff.duty_hires |-> prdata[7:6] == 2'b00)
    else $error("duty upper bits not zero in low mode");

  a_ready_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not one cycle after one wait");

  c_unlocked_write: cover property (wr_done && unlocked && hit_duty);
  c_exceed_rise: cover property (!entry_exceeded ##1 entry_exceeded);
  c_hires_ext: cover property (entry_exceeded && ext_active);
  c_bad_addr: cover property (pready && pslverr);
  c_lock_refused: cover property (wr_done && !unlocked && hit_limit);

endmodule : flut11_top
